// file: verilog/adcc_pkg.sv
// register map, field layout and reset values of the converter control block
// assumes a 32-bit apb slave with one aligned word per register
package adcc_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_RESULT_HIGH  = 8'h00;
	localparam logic [7:0] OFF_RESULT_LOW   = 8'h04;
	localparam logic [7:0] OFF_CMP_HIGH     = 8'h08;
	localparam logic [7:0] OFF_CMP_LOW      = 8'h0c;
	localparam logic [7:0] OFF_CONFIG       = 8'h10;
	localparam logic [7:0] OFF_PIN_SELECT   = 8'h14;
	localparam logic [7:0] OFF_CMP_CONTROL  = 8'h18;
	localparam logic [7:0] OFF_STATUS_ONE   = 8'h1c;

	// ==========================================================
	// converter_config fields
	localparam int CFG_LOW_POWER_BIT   = 7;
	localparam int CFG_DIV_LSB         = 5;
	localparam int CFG_LONG_SAMPLE_BIT = 4;
	localparam int CFG_MODE_LSB        = 2;
	localparam int CFG_CLK_SEL_LSB     = 0;

	// compare control and status fields
	localparam int CMP_ENABLE_BIT      = 5;
	localparam int CMP_DIRECTION_BIT   = 4;
	localparam int STATUS_DONE_BIT     = 7;

	// ==========================================================
	// encodings
	localparam logic [1:0] MODE_8BIT   = 2'h0;
	localparam logic [1:0] MODE_12BIT  = 2'h1;
	localparam logic [1:0] MODE_10BIT  = 2'h2;

	localparam logic [1:0] CLK_BUS     = 2'h0;
	localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
	localparam logic [1:0] CLK_ALT     = 2'h2;
	localparam logic [1:0] CLK_ASYNC   = 2'h3;

	// ==========================================================
	// reset values
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [11:0] RESET_RESULT = 12'h000;

endpackage : adcc_pkg

// file: verilog/adcc_clk_if.sv
// clock source and divide selection passed from the control core to the divider
// assumes both ends run on pclk
`timescale 1ns/1ps
interface adcc_clk_if;
	logic [1:0] clk_sel;
	logic [1:0] div_sel;
	logic       conv_clk_en;

	modport ctl (output clk_sel, output div_sel, input conv_clk_en);
	modport gen (input clk_sel, input div_sel, output conv_clk_en);
endinterface : adcc_clk_if

// file: verilog/adcc_clkdiv.sv
// converter clock enable: source select then divide by 1, 2, 4 or 8
// assumes alternate and internal clocks are slow pins sampled on pclk
`timescale 1ns/1ps
module adcc_clkdiv (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// external clock pins
	input  wire logic alternate_clock,
	input  wire logic internal_async_clock,
	// selection and enable out
	adcc_clk_if.gen   sel
);
	// ==========================================================
	// pin synchronisers and edge detect
	logic [1:0] alt_sync_reg;
	logic [1:0] async_sync_reg;
	logic       alt_prev_reg;
	logic       async_prev_reg;
	logic       half_reg;
	logic [2:0] count_reg;
	logic       src_en;
	logic [2:0] terminal;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_sync_reg   <= 2'h0;
			async_sync_reg <= 2'h0;
			alt_prev_reg   <= 1'b0;
			async_prev_reg <= 1'b0;
		end else begin
			alt_sync_reg   <= {alt_sync_reg[0], alternate_clock};
			async_sync_reg <= {async_sync_reg[0], internal_async_clock};
			alt_prev_reg   <= alt_sync_reg[1];
			async_prev_reg <= async_sync_reg[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_reg <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
		end
	end

	// ==========================================================
	// source select
	always_comb begin
		unique case (sel.clk_sel)
			adcc_pkg::CLK_BUS:      src_en = 1'b1;
			adcc_pkg::CLK_BUS_DIV2: src_en = half_reg;
			adcc_pkg::CLK_ALT:      src_en = alt_sync_reg[1] & ~alt_prev_reg;
			adcc_pkg::CLK_ASYNC:    src_en = async_sync_reg[1] & ~async_prev_reg;
		endcase
	end

	// ==========================================================
	// divider
	assign terminal = 3'(({2'h0, 1'b1} << sel.div_sel) - 3'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 3'h0;
		end else if (src_en) begin
			count_reg <= (count_reg >= terminal) ? 3'h0 : count_reg + 3'h1;
		end
	end

	assign sel.conv_clk_en = src_en & (count_reg >= terminal);

endmodule : adcc_clkdiv

// file: verilog/adcc_pinctl.sv
// per-channel pad gating for channels 0 to 7
// assumes pad inputs are asynchronous pins
`timescale 1ns/1ps
module adcc_pinctl #(
	parameter int CHANNELS = 8
) (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// control
	input  wire logic [CHANNELS-1:0] pin_disable,
	// port side requests
	input  wire logic [CHANNELS-1:0] pad_in,
	input  wire logic [CHANNELS-1:0] port_out_en_req,
	input  wire logic [CHANNELS-1:0] port_pull_req,
	// gated pad controls
	output logic      [CHANNELS-1:0] pad_oe,
	output logic      [CHANNELS-1:0] pull_en,
	output logic      [CHANNELS-1:0] port_read_data
);
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic [1:0] sync_reg;
			logic       read_reg;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_reg <= 2'h0;
					read_reg <= 1'b0;
				end else begin
					sync_reg <= {sync_reg[0], pad_in[ch]};
					read_reg <= sync_reg[1] & ~pin_disable[ch];
				end
			end

			assign pad_oe[ch]         = port_out_en_req[ch] & ~pin_disable[ch];
			assign pull_en[ch]        = port_pull_req[ch] & ~pin_disable[ch];
			assign port_read_data[ch] = read_reg;
		end
	endgenerate

endmodule : adcc_pinctl

// file: verilog/adcc_top.sv
// result, compare, configuration and pin control registers of the converter
// assumes an apb master on pclk and a converter core that pulses conv_done on pclk
//
// Functional notes
// - 12-bit: high register shows upper four bits, low the lower eight.
// - 10-bit: high register shows two bits; bits 11 and 10 read zero.
// - 8-bit: bits 11 to 8 read zero; all eight bits in low register.
// - results load on each completion outside a read block unless compare enabled and false.
// - on a compare event the stored value is result minus compare value.
// - 12/10-bit: high read blocks result transfer until low is read.
// - completion during the block is discarded.
// - 8-bit: no read interlock, results update regardless of reads.
// - 12-bit compare uses four low bits of compare high.
// - 10-bit compare uses compare bits 9 and 8.
// - 8-bit compare ignores compare high.
// - compare low always checks the lower eight result bits.
// - config bit 7 selects low power over high speed.
// - config bits 6:5 divide converter clock by 1, 2, 4 or 8.
// - config bit 4 selects long sample time.
// - config bits 3:2 select 8, 12 or 10-bit; 11 reserved.
// - config bits 1:0 pick bus, bus halved, alternate or internal clock.
// - pin select bit n removes port control from channel n pin.
// - direction set: true when result >= compare; clear: when less.
// - done flag sets per completion outside a read block, or true compare; write or low read clears.
// - set pin bit: output off, input reads zero, pullup off.
// - 10 and 8-bit results are rounded from the raw 12-bit value.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module adcc_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// converter core
	input  wire logic        conv_done,
	input  wire logic [11:0] conv_raw,
	output logic             converter_clock_en,
	output logic             low_power_select,
	output logic             long_sample_select,
	output logic [1:0]       conversion_mode,
	output logic             conversion_done_flag,
	// clock pins
	input  wire logic        alternate_clock,
	input  wire logic        internal_async_clock,
	// analog pads, channels 0 to 7
	input  wire logic [7:0]  pad_in,
	input  wire logic [7:0]  port_out_en_req,
	input  wire logic [7:0]  port_pull_req,
	output logic      [7:0]  pad_oe,
	output logic      [7:0]  pull_en,
	output logic      [7:0]  port_read_data
);
	// ==========================================================
	// decoding helpers
	function automatic logic [11:0] mode_mask(input logic [1:0] mode);
		unique case (mode)
			adcc_pkg::MODE_12BIT: mode_mask = 12'hfff;
			adcc_pkg::MODE_10BIT: mode_mask = 12'h3ff;
			default:              mode_mask = 12'h0ff;
		endcase
	endfunction : mode_mask

	function automatic logic interlocked(input logic [1:0] mode);
		interlocked = (mode == adcc_pkg::MODE_12BIT) || (mode == adcc_pkg::MODE_10BIT);
	endfunction : interlocked

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
		is_addr = (a == off);
	endfunction : is_addr

	// ==========================================================
	// registers
	logic [11:0] result_reg;
	logic [7:0]  compare_value_high_reg;
	logic [7:0]  compare_value_low_reg;
	logic [7:0]  converter_config_reg;
	logic [7:0]  analog_pin_select_ch0_7_reg;
	logic        compare_enable_reg;
	logic        compare_direction_reg;
	logic        done_flag_reg;
	logic        lock_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;

	// ==========================================================
	// bus decode
	logic        setup;
	logic        access;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [1:0]  mode;

	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign wr     = access & pwrite;
	assign rd     = access & ~pwrite;
	assign mode   = converter_config_reg[adcc_pkg::CFG_MODE_LSB +: 2];

	always_comb begin
		mapped = is_addr(paddr, adcc_pkg::OFF_RESULT_HIGH) ||
		         is_addr(paddr, adcc_pkg::OFF_RESULT_LOW) ||
		         is_addr(paddr, adcc_pkg::OFF_CMP_HIGH) ||
		         is_addr(paddr, adcc_pkg::OFF_CMP_LOW) ||
		         is_addr(paddr, adcc_pkg::OFF_CONFIG) ||
		         is_addr(paddr, adcc_pkg::OFF_PIN_SELECT) ||
		         is_addr(paddr, adcc_pkg::OFF_CMP_CONTROL) ||
		         is_addr(paddr, adcc_pkg::OFF_STATUS_ONE);
	end

	// zero wait states; read data is latched in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg & access;

	logic read_high;
	logic read_low;
	logic write_status;

	assign read_high    = rd & is_addr(paddr, adcc_pkg::OFF_RESULT_HIGH);
	assign read_low     = rd & is_addr(paddr, adcc_pkg::OFF_RESULT_LOW);
	assign write_status = wr & is_addr(paddr, adcc_pkg::OFF_STATUS_ONE);

	// ==========================================================
	// rounding of the raw result
	logic [10:0] sum10;
	logic [8:0]  sum8;
	logic [11:0] conv_value;

	assign sum10 = {1'b0, conv_raw[11:2]} + {10'h000, conv_raw[1]};
	assign sum8  = {1'b0, conv_raw[11:4]} + {8'h00, conv_raw[3]};

	always_comb begin
		unique case (mode)
			adcc_pkg::MODE_12BIT: conv_value = conv_raw;
			adcc_pkg::MODE_10BIT: conv_value = {2'h0, sum10[10] ? 10'h3ff : sum10[9:0]};
			default:              conv_value = {4'h0, sum8[8] ? 8'hff : sum8[7:0]};
		endcase
	end

	// ==========================================================
	// automatic compare
	logic [11:0] compare_value;
	logic        result_ge;
	logic        compare_true;
	logic [11:0] compare_diff;

	always_comb begin
		unique case (mode)
			adcc_pkg::MODE_12BIT:
				compare_value = {compare_value_high_reg[3:0], compare_value_low_reg};
			adcc_pkg::MODE_10BIT:
				compare_value = {2'h0, compare_value_high_reg[1:0], compare_value_low_reg};
			default:
				compare_value = {4'h0, compare_value_low_reg};
		endcase
	end

	assign result_ge    = conv_value >= compare_value;
	assign compare_true = compare_direction_reg ? result_ge : ~result_ge;
	// result plus two's complement of the compare value, then cut to the mode width
	assign compare_diff = 12'(conv_value + ~compare_value + 12'h001) & mode_mask(mode);

	// ==========================================================
	// result load and interlock
	logic accept;
	logic load_result;

	assign accept      = conv_done & ~(lock_reg & interlocked(mode));
	assign load_result = accept & (~compare_enable_reg | compare_true);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= adcc_pkg::RESET_RESULT;
		end else if (load_result) begin
			result_reg <= compare_enable_reg ? compare_diff : (conv_value & mode_mask(mode));
		end
	end

	// in 12 and 10-bit modes a high read holds off new results until the matching low read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_reg <= 1'b0;
		end else if (!interlocked(mode)) begin
			lock_reg <= 1'b0;
		end else if (read_low) begin
			lock_reg <= 1'b0;
		end else if (read_high) begin
			lock_reg <= 1'b1;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag_reg <= 1'b0;
		end else if (load_result) begin
			done_flag_reg <= 1'b1;
		end else if (write_status || read_low) begin
			done_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_value_high_reg      <= adcc_pkg::RESET_BYTE;
			compare_value_low_reg       <= adcc_pkg::RESET_BYTE;
			converter_config_reg        <= adcc_pkg::RESET_BYTE;
			analog_pin_select_ch0_7_reg <= adcc_pkg::RESET_BYTE;
			compare_enable_reg          <= 1'b0;
			compare_direction_reg       <= 1'b0;
		end else if (wr) begin
			if (is_addr(paddr, adcc_pkg::OFF_CMP_HIGH)) begin
				compare_value_high_reg <= pwdata[7:0];
			end
			if (is_addr(paddr, adcc_pkg::OFF_CMP_LOW)) begin
				compare_value_low_reg <= pwdata[7:0];
			end
			if (is_addr(paddr, adcc_pkg::OFF_CONFIG)) begin
				converter_config_reg <= pwdata[7:0];
			end
			if (is_addr(paddr, adcc_pkg::OFF_PIN_SELECT)) begin
				analog_pin_select_ch0_7_reg <= pwdata[7:0];
			end
			if (is_addr(paddr, adcc_pkg::OFF_CMP_CONTROL)) begin
				compare_enable_reg    <= pwdata[adcc_pkg::CMP_ENABLE_BIT];
				compare_direction_reg <= pwdata[adcc_pkg::CMP_DIRECTION_BIT];
			end
		end
	end

	// ==========================================================
	// read mux, captured during setup
	logic [31:0] read_value;

	always_comb begin
		read_value = 32'h0000_0000;
		unique case (paddr)
			adcc_pkg::OFF_RESULT_HIGH: read_value[7:0] = {4'h0, result_reg[11:8]};
			adcc_pkg::OFF_RESULT_LOW:  read_value[7:0] = result_reg[7:0];
			adcc_pkg::OFF_CMP_HIGH:    read_value[7:0] = compare_value_high_reg;
			adcc_pkg::OFF_CMP_LOW:     read_value[7:0] = compare_value_low_reg;
			adcc_pkg::OFF_CONFIG:      read_value[7:0] = converter_config_reg;
			adcc_pkg::OFF_PIN_SELECT:  read_value[7:0] = analog_pin_select_ch0_7_reg;
			adcc_pkg::OFF_CMP_CONTROL: begin
				read_value[adcc_pkg::CMP_ENABLE_BIT]    = compare_enable_reg;
				read_value[adcc_pkg::CMP_DIRECTION_BIT] = compare_direction_reg;
			end
			adcc_pkg::OFF_STATUS_ONE:  read_value[adcc_pkg::STATUS_DONE_BIT] = done_flag_reg;
			default:                   read_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : read_value;
			pslverr_reg <= ~mapped;
		end
	end

	// ==========================================================
	// converter controls
	assign low_power_select     = converter_config_reg[adcc_pkg::CFG_LOW_POWER_BIT];
	assign long_sample_select   = converter_config_reg[adcc_pkg::CFG_LONG_SAMPLE_BIT];
	assign conversion_mode      = mode;
	assign conversion_done_flag = done_flag_reg;

	adcc_clk_if clk_bus ();

	assign clk_bus.clk_sel  = converter_config_reg[adcc_pkg::CFG_CLK_SEL_LSB +: 2];
	assign clk_bus.div_sel  = converter_config_reg[adcc_pkg::CFG_DIV_LSB +: 2];
	assign converter_clock_en = clk_bus.conv_clk_en;

	adcc_clkdiv u_clkdiv (
		.pclk                 (pclk),
		.presetn              (presetn),
		.alternate_clock      (alternate_clock),
		.internal_async_clock (internal_async_clock),
		.sel                  (clk_bus.gen)
	);

	adcc_pinctl #(
		.CHANNELS (8)
	) u_pinctl (
		.pclk            (pclk),
		.presetn         (presetn),
		.pin_disable     (analog_pin_select_ch0_7_reg),
		.pad_in          (pad_in),
		.port_out_en_req (port_out_en_req),
		.port_pull_req   (port_pull_req),
		.pad_oe          (pad_oe),
		.pull_en         (pull_en),
		.port_read_data  (port_read_data)
	);

endmodule : adcc_top

// file: bench/adcc_asserts.sv
// port checker of the converter control block
// assumes binding to adcc_top, one pclk domain, async presetn
`timescale 1ns/1ps
module adcc_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	// converter and pads
	input wire logic        conv_done,
	input wire logic        converter_clock_en,
	input wire logic        low_power_select,
	input wire logic        long_sample_select,
	input wire logic [1:0]  conversion_mode,
	input wire logic        conversion_done_flag,
	input wire logic [7:0]  port_out_en_req,
	input wire logic [7:0]  port_pull_req,
	input wire logic [7:0]  pad_oe,
	input wire logic [7:0]  pull_en,
	input wire logic [7:0]  port_read_data
);
	// ==========================================================
	// shadows of written registers
	logic [7:0] cfg_reg;
	logic [7:0] pin_reg;
	logic [1:0] up_reg;
	wire        wr_acc = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= 8'h00;
			pin_reg <= 8'h00;
		end else if (wr_acc) begin
			if (paddr == adcc_pkg::OFF_CONFIG) cfg_reg <= pwdata[7:0];
			if (paddr == adcc_pkg::OFF_PIN_SELECT) pin_reg <= pwdata[7:0];
		end
	end
	// divider settles after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	end

	// ==========================================================
	// properties
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_settled;
		up_reg == 2'h3 && $stable(cfg_reg) && cfg_reg == $past(cfg_reg, 2);
	endsequence
	sequence s_status_wr;
		wr_acc && paddr == adcc_pkg::OFF_STATUS_ONE;
	endsequence
	AST_CFG_POWER: assert property (low_power_select == cfg_reg[7])
		else $error("power bit wrong");
	AST_CFG_FIELDS: assert property (
		long_sample_select == cfg_reg[4] && conversion_mode == cfg_reg[3:2])
		else $error("sample or mode wrong");
	AST_CLK_BUS_DIV1: assert property (
		s_settled ##0 (cfg_reg[6:5] == 2'h0 && cfg_reg[1:0] == 2'h0) |-> converter_clock_en)
		else $error("no clock enable");
	AST_CLK_DIVN: assert property (
		s_settled ##0 (cfg_reg[6:5] != 2'h0 && converter_clock_en) |=> !converter_clock_en)
		else $error("clock enable too fast");
	AST_PAD_GATE: assert property (
		pad_oe == (port_out_en_req & ~pin_reg) && pull_en == (port_pull_req & ~pin_reg))
		else $error("pad not gated");
	AST_PORT_READ: assert property ((port_read_data & $past(pin_reg)) == 8'h00)
		else $error("port read not zero");
	AST_FLAG_SET: assert property ($rose(conversion_done_flag) |-> $past(conv_done))
		else $error("flag set unprompted");
	AST_FLAG_CLEAR: assert property (
		s_status_wr ##0 !conv_done |=> !conversion_done_flag)
		else $error("flag not cleared");
endmodule : adcc_asserts

bind adcc_top adcc_asserts u_chk (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .conv_done,
	.converter_clock_en, .low_power_select, .long_sample_select, .conversion_mode,
	.conversion_done_flag, .port_out_en_req, .port_pull_req, .pad_oe, .pull_en,
	.port_read_data
);

// file: bench/adcc_core_model.sv
// behavioural converter core: answers a start after lat cycles
// assumes start is a one-cycle pulse and lat is at least one
`timescale 1ns/1ps
module adcc_core_model (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// request from the bench
	input wire logic        start,
	input wire logic [11:0] raw_in,
	input wire logic [3:0]  lat,
	// converter side
	output logic            conv_done,
	output logic [11:0]     conv_raw
);
	logic [3:0]  cnt;
	logic [11:0] raw;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			conv_done <= 1'b0;
			conv_raw <= 12'h000;
		end else begin
			conv_done <= 1'b0;
			// result is not held outside the done cycle
			conv_raw <= ~conv_raw;
			if (start) begin
				cnt <= lat;
				raw <= raw_in;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
				if (cnt == 4'h1) begin
					conv_done <= 1'b1;
					conv_raw <= raw;
				end
			end
		end
	end
endmodule : adcc_core_model

// file: bench/tb_top.sv
// self-checking bench of the converter control block
// assumes the core model and bound checker alongside
`timescale 1ns/1ps
module tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, conv_done, start = 1'b0, clk_en, lp, ls, flag, rerr;
	logic        alt_clk = 1'b0, async_clk = 1'b0;
	logic [7:0]  paddr = 8'h00, pad_in = 8'h00, oe_req = 8'h00, pull_req = 8'h00;
	logic [7:0]  pad_oe, pull_en, port_rd, div_cnt = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [11:0] conv_raw, raw_in = 12'h000;
	logic [1:0]  mode;
	logic [3:0]  lat = 4'h1;
	int          fails = 0, checks_done = 0;

	adcc_top dut (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .conv_done, .conv_raw, .converter_clock_en(clk_en), .low_power_select(lp),
		.long_sample_select(ls), .conversion_mode(mode), .conversion_done_flag(flag),
		.alternate_clock(alt_clk), .internal_async_clock(async_clk), .pad_in,
		.port_out_en_req(oe_req), .port_pull_req(pull_req), .pad_oe, .pull_en,
		.port_read_data(port_rd)
	);
	adcc_core_model core (.pclk, .presetn, .start, .raw_in, .lat, .conv_done, .conv_raw);

	initial begin
		forever #2.5 pclk = ~pclk;
	end
	// slow pins with exact periods of 16 and 8 cycles
	always @(posedge pclk) begin
		div_cnt <= div_cnt + 8'h01;
		if (div_cnt[2:0] == 3'h7) alt_clk <= ~alt_clk;
		if (div_cnt[1:0] == 2'h3) async_clk <= ~async_clk;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(nm, rdat, {24'h000000, e});
	endtask : rc
	task automatic conv(input logic [11:0] r);
		start <= 1'b1;
		raw_in <= r;
		@(posedge pclk);
		start <= 1'b0;
		do @(posedge pclk); while (conv_done !== 1'b1);
		@(posedge pclk);
	endtask : conv
	task automatic res_chk(input logic [11:0] e);
		rc("result_high", adcc_pkg::OFF_RESULT_HIGH, {4'h0, e[11:8]});
		rc("result_low", adcc_pkg::OFF_RESULT_LOW, e[7:0]);
	endtask : res_chk
	function automatic logic [11:0] shaped(input logic [1:0] m, input logic [11:0] r);
		logic [12:0] s;
		if (m == adcc_pkg::MODE_12BIT) return r;
		if (m == adcc_pkg::MODE_10BIT) begin
			s = {3'h0, r[11:2]} + 13'(r[1]);
			return s > 13'h3ff ? 12'h3ff : s[11:0];
		end
		s = {5'h0, r[11:4]} + 13'(r[3]);
		return s > 13'h0ff ? 12'h0ff : s[11:0];
	endfunction : shaped
	function automatic logic [12:0] ex_cmp(input logic [1:0] m, input logic [7:0] hi,
		input logic [7:0] lo, input logic dir, input logic [11:0] r);
		logic [11:0] v, c;
		v = shaped(m, r);
		c = m == adcc_pkg::MODE_12BIT ? {hi[3:0], lo} :
			m == adcc_pkg::MODE_10BIT ? {2'h0, hi[1:0], lo} : {4'h0, lo};
		return {(dir ? v >= c : v < c), (v - c) & shaped(m, 12'hfff)};
	endfunction : ex_cmp

	// ==========================================================
	// scenarios
	task automatic t_reset();
		for (int a = 0; a < 32; a += 4) rc("reset_value", 8'(a), 8'h00);
		chk("pready", 32'(pready), 32'h1);
		apb(1'b1, adcc_pkg::OFF_RESULT_LOW, 8'hff);
		rc("result_ro", adcc_pkg::OFF_RESULT_LOW, 8'h00);
		apb(1'b0, 8'h20, 8'h00);
		chk("unmapped_err", 32'(rerr), 32'h1);
	endtask : t_reset
	task automatic t_modes();
		logic [13:0] tv [6] = '{{2'h1, 12'habc}, {2'h2, 12'habc}, {2'h2, 12'hfff},
			{2'h0, 12'habc}, {2'h0, 12'hff8}, {2'h3, 12'h9a7}};
		foreach (tv[i]) begin
			apb(1'b1, adcc_pkg::OFF_CONFIG, {4'h0, tv[i][13:12], 2'h0});
			chk("mode_out", 32'(mode), 32'(tv[i][13:12]));
			conv(tv[i][11:0]);
			res_chk(shaped(tv[i][13:12], tv[i][11:0]));
		end
	endtask : t_modes
	task automatic t_lock();
		logic [1:0] m;
		logic [11:0] od, nw;
		for (int i = 0; i < 3; i++) begin
			m = i == 0 ? adcc_pkg::MODE_12BIT : i == 1 ? adcc_pkg::MODE_10BIT : adcc_pkg::MODE_8BIT;
			od = shaped(m, 12'h3c4);
			nw = shaped(m, 12'h5b8);
			apb(1'b1, adcc_pkg::OFF_CONFIG, {4'h0, m, 2'h0});
			conv(12'h3c4);
			apb(1'b0, adcc_pkg::OFF_RESULT_HIGH, 8'h00);
			conv(12'h5b8);
			rc("after_lock", adcc_pkg::OFF_RESULT_LOW, i == 2 ? nw[7:0] : od[7:0]);
			conv(12'h7e1);
			res_chk(shaped(m, 12'h7e1));
		end
	endtask : t_lock
	task automatic t_compare();
		logic [30:0] tv [7] = '{{2'h1, 8'h01, 8'h23, 1'b1, 12'h100},
			{2'h1, 8'h01, 8'h23, 1'b1, 12'h200}, {2'h1, 8'h01, 8'h23, 1'b0, 12'h100},
			{2'h2, 8'hff, 8'h10, 1'b1, 12'hfff}, {2'h2, 8'hfe, 8'h10, 1'b0, 12'h800},
			{2'h0, 8'hff, 8'h40, 1'b1, 12'h500}, {2'h0, 8'h00, 8'h40, 1'b0, 12'h500}};
		logic [1:0] m;
		logic [7:0] hi, lo;
		logic dir;
		logic [11:0] r;
		logic [12:0] e;
		foreach (tv[i]) begin
			{m, hi, lo, dir, r} = tv[i];
			e = ex_cmp(m, hi, lo, dir, r);
			apb(1'b1, adcc_pkg::OFF_CONFIG, {4'h0, m, 2'h0});
			apb(1'b1, adcc_pkg::OFF_CMP_CONTROL, 8'h00);
			conv(12'h555);
			apb(1'b1, adcc_pkg::OFF_CMP_HIGH, hi);
			apb(1'b1, adcc_pkg::OFF_CMP_LOW, lo);
			rc("cmp_high", adcc_pkg::OFF_CMP_HIGH, hi);
			apb(1'b1, adcc_pkg::OFF_CMP_CONTROL, {2'h0, 1'b1, dir, 4'h0});
			apb(1'b1, adcc_pkg::OFF_STATUS_ONE, 8'h00);
			chk("flag_clear", 32'(flag), 32'h0);
			conv(r);
			chk("flag_set", 32'(flag), 32'(e[12]));
			res_chk(e[12] ? e[11:0] : shaped(m, 12'h555));
			chk("flag_low_read", 32'(flag), 32'h0);
		end
		apb(1'b1, adcc_pkg::OFF_CMP_CONTROL, 8'h00);
	endtask : t_compare
	task automatic t_pins();
		apb(1'b1, adcc_pkg::OFF_PIN_SELECT, 8'h5a);
		rc("pin_select", adcc_pkg::OFF_PIN_SELECT, 8'h5a);
		for (int k = 0; k < 2; k++) begin
			oe_req <= k ? 8'h0f : 8'hff;
			pull_req <= k ? 8'hf0 : 8'hff;
			pad_in <= k ? 8'h3c : 8'hff;
			repeat (5) @(posedge pclk);
			chk("pad_oe", 32'(pad_oe), k ? 32'h05 : 32'ha5);
			chk("pull_en", 32'(pull_en), k ? 32'ha0 : 32'ha5);
			chk("port_read", 32'(port_rd), k ? 32'h24 : 32'ha5);
		end
	endtask : t_pins
	task automatic t_cfg();
		logic [15:0] tv [10] = '{{8'h80, 8'd64}, {8'h10, 8'd64}, {8'h60, 8'd8},
			{8'h01, 8'd32}, {8'h21, 8'd16}, {8'h41, 8'd8}, {8'h02, 8'd4}, {8'h42, 8'd1},
			{8'h03, 8'd8}, {8'h63, 8'd1}};
		int n;
		foreach (tv[i]) begin
			apb(1'b1, adcc_pkg::OFF_CONFIG, tv[i][15:8]);
			chk("low_power", 32'(lp), 32'(tv[i][15]));
			chk("long_sample", 32'(ls), 32'(tv[i][12]));
			repeat (40) @(posedge pclk);
			n = 0;
			repeat (64) begin
				@(posedge pclk);
				n += int'(clk_en === 1'b1);
			end
			chk("clk_rate", 32'(n), 32'(tv[i][7:0]));
		end
	endtask : t_cfg

	task automatic finish_test();
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	initial begin
		repeat (30000) @(posedge pclk);
		fails++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_modes();
		t_lock();
		lat <= 4'h9;
		t_compare();
		t_pins();
		t_cfg();
		// second reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("config_after_reset", adcc_pkg::OFF_CONFIG, 8'h00);
		finish_test();
	end
endmodule : tb_top
